// File: src/fnbi_pkg.sv
// constants, register map and state types of the flash bus interface
package fnbi_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int ACC_INIT_NS = 200;
   localparam int ACC_PAGE_NS = 100;
   localparam int PROG_NS = 2000;
   localparam int WAKE_NS = 1000;
   localparam int DPD_EXIT_US = 75;
   localparam int TMR_W = 12;
   // least times, rounded up to whole core cycles
   localparam logic [11:0] ACC_INIT_CYC =
      12'((ACC_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] ACC_PAGE_CYC =
      12'((ACC_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] PROG_CYC =
      12'((PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] WAKE_CYC =
      12'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] DPD_EXIT_CYC =
      12'((DPD_EXIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int MEM_AW = 8;
   localparam int MEM_DEPTH = 256;
   localparam logic [7:0] REG_RCR = 8'h00;
   localparam logic [7:0] REG_ECR = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_STATE = 8'h0C;
   localparam logic [7:0] REG_VARIANT = 8'h10;
   localparam logic [15:0] RCR_RESET = 16'hA007;
   localparam logic [15:0] ECR_RESET = 16'h0000;
   localparam logic [15:0] VARIANT_RESET = 16'h0000;
   localparam int RCR_ASYNC_BIT = 15;
   localparam int RCR_LC_LSB = 11;
   localparam int RCR_WPOL_BIT = 10;
   localparam int ECR_DSE_BIT = 15;
   localparam int ECR_DSP_BIT = 14;
   localparam int SR_READY_BIT = 7;
   localparam int SR_ERASE_ERR_BIT = 5;
   localparam int SR_PROG_ERR_BIT = 4;
   localparam int VAR_SHARED_BIT = 0;
   localparam int VAR_FAST_BIT = 1;
   localparam logic [2:0] BL_8 = 3'h1;
   localparam logic [2:0] BL_16 = 3'h2;
   localparam logic [2:0] BL_CONT = 3'h7;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
   localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
   localparam logic [15:0] INVALID_WORD = 16'h0000;
   typedef enum logic [2:0] {
      P_RESET = 3'h0,
      P_WAKE = 3'h1,
      P_RUN = 3'h2,
      P_DPD = 3'h3,
      P_EXIT = 3'h4
   } fnbi_pwr_t;
   typedef enum logic [1:0] {
      B_IDLE = 2'h0,
      B_LAT = 2'h1,
      B_BURST = 2'h2
   } fnbi_burst_t;
endpackage

// File: src/fnbi_timer.sv
// down counter: load a cycle count, done pulses when it runs out
`timescale 1ns/1ns
module fnbi_timer
   import fnbi_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic clear,
   input wire logic [TMR_W-1:0] load_val,
   output logic busy,
   output logic done
);
   logic [TMR_W-1:0] cnt_reg;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_reg <= '0;
      else if (clear)
         cnt_reg <= '0;
      else if (load)
         cnt_reg <= load_val;
      else if (cnt_reg != '0)
         cnt_reg <= cnt_reg - 1'b1;
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         done <= 1'b0;
      else
         done <= !load && !clear && (cnt_reg == 12'h001);
   end
   assign busy = (cnt_reg != '0);
endmodule

// File: src/fnbi_mem.sv
// small word array standing in for the flash cells, registered read
`timescale 1ns/1ns
module fnbi_mem
   import fnbi_pkg::*;
(
   input wire logic core_clk,
   input wire logic [MEM_AW-1:0] rd_addr,
   output logic [15:0] rd_data,
   input wire logic wr_en,
   input wire logic [MEM_AW-1:0] wr_addr,
   input wire logic [15:0] wr_data
);
   logic [15:0] cells [MEM_DEPTH];
   always_ff @(posedge core_clk)
   begin
      if (wr_en)
         cells[wr_addr] <= wr_data;
      rd_data <= cells[rd_addr];
   end
endmodule

// File: src/fnbi_flash_if.sv
// device side of the 16-bit nor flash bus interface
//
// How it works
// - reset pin aborts work, floats outputs, wakes later
// - data driven only during a read with output drive
// - async select bit picks async or burst reads
// - page reads only on separate-bus variant
// - async address latched when address valid rises
// - page of sixteen words, low bits pick word
// - page reads: ready deasserted, clock ignored, valid optional
// - read config holds latency, burst length, polarity
// - burst address latch differs between slow and fast
// - first word after latency, then one per edge
// - non-array burst repeats the same word
// - ready polarity low-true after reset, tracks validity
// - ready floats or deasserts on writes, floats deselected
// - writes latch asynchronously on strobe or select rise
// - deep sleep when enabled and pin asserted
// - deep sleep exit after latency once pin deasserts
// - deep sleep entry kills program, word left invalid
// - deep sleep keeps config, resets status to default
// - deselect floats data, program continues
// - reads allowed inside two-cycle command, next write ends it
// - sequence error sets both error bits
`timescale 1ns/1ns
module fnbi_flash_if
   import fnbi_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reset_pin_n,
   input wire logic deep_sleep_request,
   input wire logic chip_select_n,
   input wire logic output_drive_n,
   input wire logic write_strobe_n,
   input wire logic address_valid_n,
   input wire logic bus_clk,
   input wire logic [15:0] address_in,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   output logic data_not_ready,
   output logic data_not_ready_oe,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata
);
   fnbi_pwr_t pwr_reg;
   fnbi_burst_t bst_reg;
   logic [15:0] read_config_reg, extended_config_reg, variant_reg;
   logic [15:0] ra_reg, sensed_reg, burst_reg, prog_addr_reg, prog_data_reg;
   logic cs_d, we_d, adv_d, clk_d, rd_d, adv_armed_reg;
   logic err_erase_reg, err_prog_reg, status_mode_reg;
   logic pend_prog_reg, pend_cfg_reg;
   logic [3:0] lat_reg;
   logic [7:0] words_reg;
   logic pwr_run, shared, fast, async_mode, ds_asserted;
   logic clk_edge, adv_rise, rd_cond, wr_cond, write_end, sync_latch;
   logic [15:0] latch_src, wr_addr, word, burst_next, status_word;
   logic [3:0] lat_count;
   logic [2:0] blen;
   logic [7:0] cmd;
   logic burst_more, seq_err, prog_start, dpd_enter;
   logic pwr_busy, pwr_done, acc_busy, acc_done, prog_busy, prog_done;
   logic acc_load, pwr_load;
   logic [TMR_W-1:0] acc_val, pwr_val;
   logic [15:0] mem_rdata;
   logic mem_we;
   assign pwr_run = (pwr_reg == P_RUN);
   assign shared = variant_reg[VAR_SHARED_BIT];
   assign fast = variant_reg[VAR_FAST_BIT];
   assign async_mode = read_config_reg[RCR_ASYNC_BIT];
   assign lat_count = read_config_reg[RCR_LC_LSB+3:RCR_LC_LSB];
   assign blen = read_config_reg[2:0];
   // asserted level of the sleep pin follows the polarity bit
   assign ds_asserted =
      (deep_sleep_request == extended_config_reg[ECR_DSP_BIT]);
   assign clk_edge = bus_clk && !clk_d;
   assign adv_rise = address_valid_n && !adv_d;
   assign rd_cond = !chip_select_n && !output_drive_n && write_strobe_n;
   assign wr_cond = !chip_select_n && !write_strobe_n && output_drive_n;
   // first rise of either strobe ends the write
   assign write_end = pwr_run && !cs_d && !we_d
      && (chip_select_n || write_strobe_n);
   assign latch_src = shared ? data_in : address_in;
   assign wr_addr = shared ? ra_reg : address_in;
   assign cmd = data_in[7:0];
   assign sync_latch = pwr_run && !async_mode && (fast
      ? (clk_edge && !address_valid_n)
      : (adv_armed_reg && (adv_rise
         || (clk_edge && !address_valid_n))));
   assign seq_err = write_end && pend_cfg_reg
      && (cmd != CMD_CFG_CONFIRM);
   assign prog_start = write_end && pend_prog_reg;
   assign dpd_enter = pwr_run && extended_config_reg[ECR_DSE_BIT]
      && ds_asserted;
   assign status_word = {8'h00, !prog_busy, 1'b0, err_erase_reg,
      err_prog_reg, 4'h0};
   assign word = status_mode_reg ? status_word : mem_rdata;
   assign burst_more = (blen == BL_CONT)
      || (words_reg < ((blen == BL_8) ? 8'h08 : 8'h10));
   always_comb
   begin
      burst_next = burst_reg + 16'h0001;
      // fixed lengths wrap inside their aligned group
      if (blen == BL_8)
         burst_next = {burst_reg[15:3], burst_next[2:0]};
      else if (blen == BL_16)
         burst_next = {burst_reg[15:4], burst_next[3:0]};
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_d <= 1'b1;
         we_d <= 1'b1;
         adv_d <= 1'b1;
         clk_d <= 1'b0;
         rd_d <= 1'b0;
      end
      else
      begin
         cs_d <= chip_select_n;
         we_d <= write_strobe_n;
         adv_d <= address_valid_n;
         clk_d <= bus_clk;
         rd_d <= rd_cond;
      end
   end
   // power state: reset pin beats everything
   always_comb
   begin
      pwr_load = 1'b0;
      pwr_val = WAKE_CYC;
      if (pwr_reg == P_RESET && reset_pin_n)
         pwr_load = 1'b1;
      else if (pwr_reg == P_DPD && !ds_asserted)
      begin
         pwr_load = 1'b1;
         pwr_val = DPD_EXIT_CYC;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pwr_reg <= P_RESET;
      else if (!reset_pin_n)
         pwr_reg <= P_RESET;
      else
         case (pwr_reg)
            P_RESET: pwr_reg <= P_WAKE;
            P_WAKE: if (pwr_done) pwr_reg <= P_RUN;
            P_RUN: if (dpd_enter) pwr_reg <= P_DPD;
            P_DPD: if (!ds_asserted) pwr_reg <= P_EXIT;
            P_EXIT: if (pwr_done) pwr_reg <= P_RUN;
            default: pwr_reg <= P_RESET;
         endcase
   end
   fnbi_timer u_pwr_tmr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(pwr_load),
      .clear(!reset_pin_n),
      .load_val(pwr_val),
      .busy(pwr_busy),
      .done(pwr_done)
   );
   // read address capture for async and burst reads
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ra_reg <= 16'h0000;
         adv_armed_reg <= 1'b1;
      end
      else if (pwr_run)
      begin
         if (!address_valid_n && adv_d)
            adv_armed_reg <= 1'b1;
         else if (sync_latch)
            adv_armed_reg <= 1'b0;
         if (async_mode)
         begin
            if (adv_rise || wr_cond)
               ra_reg <= shared ? data_in : ra_reg;
            if (adv_rise && !shared)
               ra_reg <= address_in;
            else if (!shared && !address_valid_n)
               ra_reg <= address_in;
         end
         else if (sync_latch || (shared && adv_rise))
            ra_reg <= latch_src;
      end
   end
   // async access: new page costs the initial delay, same page less
   assign acc_load = pwr_run && async_mode && rd_cond
      && (!rd_d || ra_reg != sensed_reg);
   assign acc_val = (!shared && rd_d
      && ra_reg[15:4] == sensed_reg[15:4])
      ? ACC_PAGE_CYC : ACC_INIT_CYC;
   fnbi_timer u_acc_tmr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(acc_load),
      .clear(!pwr_run),
      .load_val(acc_val),
      .busy(acc_busy),
      .done(acc_done)
   );
   // burst sequencer, driven by sampled bus clock edges
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bst_reg <= B_IDLE;
         lat_reg <= 4'h0;
         words_reg <= 8'h00;
         burst_reg <= 16'h0000;
      end
      else if (!pwr_run || async_mode || chip_select_n)
         bst_reg <= B_IDLE;
      else if (sync_latch)
      begin
         bst_reg <= B_LAT;
         lat_reg <= 4'h1;
         burst_reg <= latch_src;
         words_reg <= 8'h00;
      end
      else if (clk_edge)
         case (bst_reg)
            B_LAT:
            begin
               if (lat_reg >= lat_count)
                  bst_reg <= B_BURST;
               else
                  lat_reg <= lat_reg + 4'h1;
            end
            B_BURST:
            begin
               if (burst_more)
               begin
                  words_reg <= words_reg + 8'h01;
                  if (!status_mode_reg)
                     burst_reg <= burst_next;
               end
            end
            B_IDLE: bst_reg <= B_IDLE;
            default: bst_reg <= B_IDLE;
         endcase
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         sensed_reg <= 16'h0000;
      else if (acc_load)
         sensed_reg <= ra_reg;
   end
   fnbi_mem u_mem (
      .core_clk(core_clk),
      .rd_addr(async_mode ? ra_reg[MEM_AW-1:0] : burst_reg[MEM_AW-1:0]),
      .rd_data(mem_rdata),
      .wr_en(mem_we),
      .wr_addr(prog_addr_reg[MEM_AW-1:0]),
      .wr_data(prog_data_reg)
   );
   // data bus: driven only in a read cycle while the device is up
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_out <= 16'h0000;
         data_oe <= 1'b0;
      end
      else
      begin
         data_oe <= pwr_run && reset_pin_n && rd_cond;
         if (async_mode && acc_done)
            data_out <= word;
         else if (!async_mode && clk_edge && bst_reg != B_IDLE)
            data_out <= word;
      end
   end
   // ready pin: asserted level equals the polarity bit
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_not_ready <= 1'b1;
         data_not_ready_oe <= 1'b0;
      end
      else
      begin
         if (rd_cond && !async_mode && bst_reg != B_BURST)
            data_not_ready <= read_config_reg[RCR_WPOL_BIT];
         else
            data_not_ready <= !read_config_reg[RCR_WPOL_BIT];
         if (!pwr_run || !reset_pin_n || chip_select_n)
            data_not_ready_oe <= 1'b0;
         else if (rd_cond)
            data_not_ready_oe <= 1'b1;
         else
            data_not_ready_oe <= shared;
      end
   end
   // command decode on the end of each bus write
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_mode_reg <= 1'b0;
         pend_prog_reg <= 1'b0;
         pend_cfg_reg <= 1'b0;
      end
      else if (!pwr_run)
      begin
         pend_prog_reg <= 1'b0;
         pend_cfg_reg <= 1'b0;
         if (pwr_reg == P_RESET)
            status_mode_reg <= 1'b0;
      end
      else if (write_end)
      begin
         pend_prog_reg <= !pend_prog_reg && !pend_cfg_reg
            && cmd == CMD_PROGRAM;
         pend_cfg_reg <= !pend_prog_reg && !pend_cfg_reg
            && cmd == CMD_CFG_SETUP;
         if (!pend_prog_reg && !pend_cfg_reg)
         begin
            if (cmd == CMD_READ_ARRAY)
               status_mode_reg <= 1'b0;
            else if (cmd == CMD_READ_STATUS || cmd == CMD_PROGRAM)
               status_mode_reg <= 1'b1;
         end
      end
   end
   // program runs on even with chip select released
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prog_addr_reg <= 16'h0000;
         prog_data_reg <= 16'h0000;
      end
      else if (prog_start && !prog_busy)
      begin
         prog_addr_reg <= wr_addr;
         prog_data_reg <= data_in;
      end
      else if (dpd_enter && prog_busy)
         prog_data_reg <= INVALID_WORD;
   end
   fnbi_timer u_prog_tmr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(prog_start && !prog_busy),
      .clear(!reset_pin_n || (pwr_reg == P_DPD)),
      .load_val(PROG_CYC),
      .busy(prog_busy),
      .done(prog_done)
   );
   assign mem_we = prog_done || (pwr_reg == P_DPD && prog_busy);
   // status errors: hardware set wins over software clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         err_erase_reg <= 1'b0;
         err_prog_reg <= 1'b0;
      end
      else if (pwr_reg == P_RESET || dpd_enter)
      begin
         err_erase_reg <= 1'b0;
         err_prog_reg <= 1'b0;
      end
      else if (seq_err)
      begin
         err_erase_reg <= 1'b1;
         err_prog_reg <= 1'b1;
      end
      else if ((write_end && !pend_prog_reg && cmd == CMD_CLEAR_STATUS)
         || (reg_wr && reg_addr == REG_STATUS))
      begin
         err_erase_reg <= 1'b0;
         err_prog_reg <= 1'b0;
      end
   end
   // configuration survives deep sleep, resets with the reset pin
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         read_config_reg <= RCR_RESET;
         extended_config_reg <= ECR_RESET;
         variant_reg <= VARIANT_RESET;
      end
      else if (pwr_reg == P_RESET)
      begin
         read_config_reg <= RCR_RESET;
         extended_config_reg <= ECR_RESET;
      end
      else if (write_end && pend_cfg_reg && !seq_err)
         read_config_reg <= wr_addr;
      else if (reg_wr)
         case (reg_addr)
            REG_RCR: read_config_reg <= reg_wdata;
            REG_ECR: extended_config_reg <= reg_wdata;
            REG_VARIANT: variant_reg <= {14'h0000, reg_wdata[1:0]};
            default: read_config_reg <= read_config_reg;
         endcase
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
         case (reg_addr)
            REG_RCR: reg_rdata <= read_config_reg;
            REG_ECR: reg_rdata <= extended_config_reg;
            REG_STATUS: reg_rdata <= status_word;
            REG_STATE: reg_rdata <= {9'h000, pend_cfg_reg, pend_prog_reg,
               bst_reg, pwr_reg};
            REG_VARIANT: reg_rdata <= variant_reg;
            default: reg_rdata <= 16'h0000;
         endcase
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence sleep_ready_s;
      pwr_run && extended_config_reg[ECR_DSE_BIT] && ds_asserted;
   endsequence
   sequence bad_confirm_s;
      write_end && pend_cfg_reg && cmd != CMD_CFG_CONFIRM;
   endsequence
   sequence exit_begin_s;
      pwr_reg == P_DPD ##1 pwr_reg == P_EXIT;
   endsequence
   reset_floats_a: assert property (
      !reset_pin_n |=> !data_oe && !data_not_ready_oe)
      else $error("outputs not floated under reset pin");
   drive_on_read_a: assert property (
      data_oe |-> $past(rd_cond) && $past(pwr_run))
      else $error("data driven outside a read");
   config_default_a: assert property (
      pwr_reg == P_RESET |=> read_config_reg == RCR_RESET)
      else $error("read config not at default after reset");
   async_ready_a: assert property (
      pwr_run && async_mode && rd_cond && reset_pin_n |=>
      data_not_ready_oe && data_not_ready != read_config_reg[RCR_WPOL_BIT])
      else $error("ready asserted during async read");
   fast_latch_a: assert property (
      pwr_run && !async_mode && fast && clk_edge && !address_valid_n
      |=> ra_reg == $past(latch_src))
      else $error("fast part missed last clock latch");
   first_word_a: assert property (
      bst_reg == B_LAT && clk_edge && lat_reg >= lat_count && pwr_run
      && !async_mode && !chip_select_n && !sync_latch
      |=> bst_reg == B_BURST && data_out == $past(word))
      else $error("first burst word not presented after latency");
   write_ready_a: assert property (
      wr_cond && !shared && pwr_run |=> !data_not_ready_oe)
      else $error("ready driven during write on separate bus");
   standby_float_a: assert property (
      chip_select_n |=> !data_oe && !data_not_ready_oe)
      else $error("outputs driven while deselected");
   sleep_entry_a: assert property (
      sleep_ready_s |=> pwr_reg == P_DPD || pwr_reg == P_RESET)
      else $error("deep sleep not entered");
   exit_wait_a: assert property (
      exit_begin_s |-> (pwr_reg != P_RUN) [*8])
      else $error("deep sleep exit too early");
   sleep_status_a: assert property (
      pwr_reg == P_DPD |-> !err_erase_reg && !err_prog_reg
      && read_config_reg == $past(read_config_reg) || reg_wr)
      else $error("status not cleared or config lost in deep sleep");
   seq_error_a: assert property (
      bad_confirm_s |=> err_erase_reg && err_prog_reg
      && $stable(read_config_reg))
      else $error("command sequence error not reported");
endmodule

// File: bench/fnbi_host.sv
// host model: drives the flash control pins like a memory controller
`timescale 1ns/1ns
module fnbi_host (
   input wire logic clk,
   input wire logic [15:0] dq,
   input wire logic doe,
   input wire logic wt,
   output logic bclk,
   output logic cs_n,
   output logic oe_n,
   output logic we_n,
   output logic adv_n,
   output logic [15:0] addr,
   output logic [15:0] data
);
   initial
   begin
      {cs_n, oe_n, we_n, adv_n} = 4'hF;
      addr = 16'h0000;
      data = 16'hFFFF;
      bclk = 1'b0;
   end
   // burst read: the bus clock runs only inside the frame, four core
   // cycles a period; wait is taken after the first and the last edge
   task automatic brd(input logic [15:0] a, output logic [15:0] q,
      output logic w0, output logic w1);
      @(posedge clk);
      cs_n <= 1'b0;
      oe_n <= 1'b0;
      adv_n <= 1'b0;
      addr <= a;
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clk);
         bclk <= 1'b1;
         repeat (2) @(posedge clk);
         bclk <= 1'b0;
         @(posedge clk);
         if (i == 0)
            w0 = wt;
      end
      q = dq;
      w1 = wt;
      cs_n <= 1'b1;
      oe_n <= 1'b1;
      adv_n <= 1'b1;
   endtask
   // output drive stays high for the whole write
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      cs_n <= 1'b0;
      we_n <= 1'b0;
      addr <= a;
      data <= d;
      @(posedge clk);
      cs_n <= 1'b1;
      we_n <= 1'b1;
      @(posedge clk);
      data <= ~d;
   endtask
   // select and address valid both rise at the end, so the next cycle
   // always starts from a toggled select
   task automatic rd(input logic [15:0] a, output logic [15:0] q,
      output logic en);
      @(posedge clk);
      cs_n <= 1'b0;
      oe_n <= 1'b0;
      adv_n <= 1'b0;
      addr <= a;
      repeat (5) @(posedge clk);
      q = dq;
      en = doe;
      cs_n <= 1'b1;
      oe_n <= 1'b1;
      adv_n <= 1'b1;
   endtask
endmodule

// File: bench/tb_nor_flash_bus_interface.sv
// self-checking bench for the flash bus interface
`timescale 1ns/1ns
module tb_nor_flash_bus_interface
   import fnbi_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_pin_n = 1'b1;
   logic dsr = 1'b1;
   logic cs_n, oe_n, we_n, adv_n, doe, dnr, dnr_oe, en;
   logic bclk, w0, w1;
   logic [15:0] addr, din, dout, q, reg_rdata;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   int n_errors = 0;
   int tests_run = 0;
   always #50 core_clk = ~core_clk;
   fnbi_flash_if u_dut (.core_clk(core_clk), .rst_n(rst_n),
      .reset_pin_n(reset_pin_n), .deep_sleep_request(dsr),
      .chip_select_n(cs_n), .output_drive_n(oe_n),
      .write_strobe_n(we_n), .address_valid_n(adv_n),
      .bus_clk(bclk), .address_in(addr), .data_in(din),
      .data_out(dout), .data_oe(doe), .data_not_ready(dnr),
      .data_not_ready_oe(dnr_oe), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   fnbi_host u_host (.clk(core_clk), .dq(dout), .doe(doe), .wt(dnr),
      .bclk(bclk), .cs_n(cs_n),
      .oe_n(oe_n), .we_n(we_n), .adv_n(adv_n), .addr(addr), .data(din));
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rw(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rr(input logic [7:0] a, input logic [15:0] exp,
      input string what);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      check(what, reg_rdata, exp);
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (20) @(posedge core_clk);
      rr(REG_RCR, RCR_RESET, "rcr");
      rr(REG_ECR, ECR_RESET, "ecr");
      rr(REG_STATUS, 16'h0080, "status");
      rr(8'h20, 16'h0000, "unmapped");
      check("wait enable idle", {15'h0000, dnr_oe}, 16'h0000);
      u_host.wr(16'h0005, 16'h0040);
      u_host.wr(16'h0005, 16'h1234);
      // program length is fixed by the core clock count
      repeat (PROG_CYC + 5) @(posedge core_clk);
      rr(REG_STATUS, 16'h0080, "prog done");
      u_host.wr(16'h0000, 16'h00FF);
      u_host.rd(16'h0005, q, en);
      check("array word", q, 16'h1234);
      check("data drive", {15'h0000, en}, 16'h0001);
      repeat (3) @(posedge core_clk);
      check("standby float", {15'h0000, doe}, 16'h0000);
      u_host.wr(16'h0000, 16'h0060);
      u_host.wr(16'h0000, 16'h0000);
      rr(REG_STATUS, 16'h00B0, "seq error");
      u_host.wr(16'h0000, 16'h0060);
      u_host.rd(16'h0005, q, en);
      u_host.wr(16'h2007, 16'h0003);
      rr(REG_RCR, 16'h2007, "rcr load");
      u_host.brd(16'h0005, q, w0, w1);
      check("burst wait", {15'h0000, w0}, 16'h0000);
      check("burst ready", {15'h0000, w1}, 16'h0001);
      check("burst word", q, 16'h1234);
      rw(REG_ECR, 16'h8000);
      dsr <= 1'b0;
      repeat (5) @(posedge core_clk);
      rr(REG_STATE, {13'h0000, P_DPD}, "sleep");
      rr(REG_STATUS, 16'h0080, "sleep status");
      rr(REG_RCR, 16'h2007, "sleep rcr");
      dsr <= 1'b1;
      repeat (DPD_EXIT_CYC + 20) @(posedge core_clk);
      rr(REG_STATE, {13'h0000, P_RUN}, "wake");
      reset_pin_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rr(REG_RCR, RCR_RESET, "pin reset rcr");
      check("pin reset float", {15'h0000, doe}, 16'h0000);
      reset_pin_n <= 1'b1;
      repeat (20) @(posedge core_clk);
      u_host.rd(16'h0005, q, en);
      check("after reset", q, 16'h1234);
      wrap_up;
   end
endmodule
